// ### tb/hpm_mem_model.sv
// on-chip ram model answering the dma bus behind the host port
`timescale 1ns/1ps
`default_nettype none
module hpm_mem_model (
  input  wire logic        clock,
  input  wire logic        dma_req,
  input  wire logic        dma_we,
  input  wire logic [17:0] dma_addr,
  input  wire logic [15:0] dma_wdata,
  input  wire logic [3:0]  wait_cyc,
  output logic      [15:0] dma_rdata,
  output logic             dma_ack
);
  logic [15:0] mem [0:262143];
  // answer each request after wait_cyc cycles, then scramble read data
  initial begin
    dma_ack = 1'b0;
    dma_rdata = 16'h5555;
    // every location starts cleared
    for (int a = 0; a < 262144; a++) begin
      mem[a] = 16'h0000;
    end
    forever begin
      @(negedge clock);
      if (dma_req === 1'b1) begin
        repeat (wait_cyc) @(negedge clock);
        if (dma_we) mem[dma_addr] = dma_wdata;
        dma_rdata = mem[dma_addr];
        dma_ack = 1'b1;
        @(negedge clock);
        dma_ack = 1'b0;
        dma_rdata = ~dma_rdata;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/hpm_props.sv
// assertion checker for the host port block
`timescale 1ns/1ps
`default_nettype none
module hpm_props (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        halfword_width_strap,
  input wire logic        host_chip_select_n,
  input wire logic        data_strobe_one_n,
  input wire logic        data_strobe_two_n,
  input wire logic        host_read_write_select,
  input wire logic        host_wait_ready,
  input wire logic        host_data_bus_oe,
  input wire logic        dma_req,
  input wire logic        dma_we,
  input wire logic        dma_ack,
  input wire logic        dsp_mem_req,
  input wire logic        dsp_stall,
  input wire logic [17:0] host_address_bus,
  input wire logic [17:0] dma_addr
);
  wire logic strobe;
  wire logic low_map;
  // --------------------------------
  // access start and address decode
  // --------------------------------
  assign strobe  = !host_chip_select_n && (!data_strobe_one_n || !data_strobe_two_n);
  assign low_map = host_address_bus >= 18'h00060 && host_address_bus <= 18'h07fff;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence hw_start;
    halfword_width_strap && $rose(strobe);
  endsequence
  dma_launch_a: assert property (hw_start ##0 low_map |=> dma_req &&
    dma_addr == $past(host_address_bus) && dma_we == !$past(host_read_write_select))
    else $error("access did not launch the right dma");
  reserved_nodma_a: assert property (hw_start ##0 host_address_bus < 18'h00060
    |=> !dma_req [*3]) else $error("reserved address launched dma");
  dma_hold_a: assert property (dma_req && !dma_ack |=> dma_req &&
    $stable(dma_addr) && $stable(dma_we)) else $error("dma request not held");
  ready_after_ack_a: assert property (dma_req && dma_ack |-> ##[1:2] host_wait_ready)
    else $error("ready late after dma ack");
  ready_no_dma_a: assert property (host_wait_ready |-> !dma_req)
    else $error("ready while dma pending");
  ready_release_a: assert property (host_wait_ready && !strobe |=> !host_wait_ready)
    else $error("ready stayed after strobe release");
  oe_ready_a: assert property (host_data_bus_oe |-> host_wait_ready)
    else $error("data driven outside ready");
  stall_pulse_a: assert property (dsp_stall |=> !dsp_stall)
    else $error("dsp stall longer than one cycle");
  stall_cause_a: assert property ($rose(dsp_stall) |-> $past(dsp_mem_req) && $past(dma_req))
    else $error("dsp stall without contention");
endmodule
bind hpm_host_port hpm_props u_hpm_props (.clock(clock), .rst_n(rst_n),
  .halfword_width_strap(halfword_width_strap), .host_chip_select_n(host_chip_select_n),
  .data_strobe_one_n(data_strobe_one_n), .data_strobe_two_n(data_strobe_two_n),
  .host_read_write_select(host_read_write_select), .host_wait_ready(host_wait_ready),
  .host_data_bus_oe(host_data_bus_oe), .dma_req(dma_req), .dma_we(dma_we),
  .dma_ack(dma_ack), .dsp_mem_req(dsp_mem_req), .dsp_stall(dsp_stall),
  .host_address_bus(host_address_bus), .dma_addr(dma_addr));
`default_nettype wire

// ### tb/testbench.sv
// self-checking testbench for the host port block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clock, rst_n, strap, keep_en, cs_n, ds1_n, rw, half, dmem, cwr;
  logic        oe, rdy, dreq, dwe, ack, stall, rsv, dko, ako, ds2_n, ds_pick, qoe;
  logic [1:0]  sel;
  logic [3:0]  wcyc;
  logic [17:0] addr, daddr, akl;
  logic [15:0] hd_drv, hd_in, cwd, q, dout, rdata, ctrl, dwd, dkl;
  int          err_count, n_tests, stall_seen, i;
  // wire level of the host data bus
  assign hd_in = oe ? dout : hd_drv;
  hpm_host_port u_hpm_host_port (.clock(clock), .rst_n(rst_n), .halfword_width_strap(strap),
    .host_bus_keeper_enable(keep_en), .host_chip_select_n(cs_n), .data_strobe_one_n(ds1_n),
    .data_strobe_two_n(ds2_n), .host_read_write_select(rw), .byte_half_select(half),
    .access_control_select(sel), .host_address_bus(addr), .host_data_bus_in(hd_in),
    .host_data_bus_out(dout), .host_data_bus_oe(oe), .host_wait_ready(rdy), .dma_req(dreq),
    .dma_we(dwe), .dma_addr(daddr), .dma_wdata(dwd), .dma_rdata(rdata), .dma_ack(ack),
    .dsp_mem_req(dmem), .dsp_stall(stall), .dsp_ctrl_wr(cwr), .dsp_ctrl_wdata(cwd),
    .host_control_reg(ctrl), .addr_reserved(rsv), .data_keeper_on(dko),
    .addr_keeper_on(ako), .data_keeper_level(dkl), .addr_keeper_level(akl));
  hpm_mem_model u_hpm_mem_model (.clock(clock), .dma_req(dreq), .dma_we(dwe),
    .dma_addr(daddr), .dma_wdata(dwd), .wait_cyc(wcyc), .dma_rdata(rdata), .dma_ack(ack));
  // clock kept running for every access
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) if (stall === 1'b1) stall_seen++;
  // --------------------------------
  // shared tasks
  // --------------------------------
  task check(input string what, input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wait_rdy(input logic lvl);
    int k;
    for (k = 0; k < 60 && rdy !== lvl; k++) begin
      @(posedge clock);
      #1;
    end
    if (rdy !== lvl) begin
      err_count++;
      $display("ERROR ready expected %b seen timeout", lvl);
      report_and_stop;
    end
  endtask
  task hacc(input logic r, input logic [1:0] s, input logic h, input logic [17:0] a,
            input logic [15:0] d);
    // select and one strobe start it
    @(negedge clock);
    rw = r;
    sel = s;
    half = h;
    addr = a;
    hd_drv = d;
    cs_n = 1'b0;
    ds1_n = ds_pick;
    ds2_n = !ds_pick;
    wait_rdy(1'b1);
    q = dout;
    qoe = oe;
    @(negedge clock);
    cs_n = 1'b1;
    ds1_n = 1'b1;
    ds2_n = 1'b1;
    hd_drv = ~d;
    wait_rdy(1'b0);
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task t_byte;
    hacc(0, 2'h2, 0, 0, 16'h0080); hacc(0, 2'h2, 1, 0, 16'h0000);
    hacc(0, 2'h1, 0, 0, 16'h00cd); hacc(0, 2'h1, 1, 0, 16'h00ab);
    hacc(0, 2'h3, 0, 0, 16'h0011); hacc(0, 2'h3, 1, 0, 16'h0022);
    check("byte word", u_hpm_mem_model.mem[18'h80], 16'habcd);
    check("autoinc word", u_hpm_mem_model.mem[18'h81], 16'h2211);
    hacc(0, 2'h2, 0, 0, 16'h0080);
    hacc(1, 2'h3, 0, 0, 0);
    check("low byte", q[7:0], 8'hcd);
    hacc(1, 2'h3, 1, 0, 0);
    check("high byte", q[7:0], 8'hab);
    hacc(1, 2'h1, 0, 0, 0);
    check("inc low byte", q[7:0], 8'hcd);
    hacc(1, 2'h1, 1, 0, 0);
    hacc(1, 2'h2, 0, 0, 0);
    check("addr after inc", q[7:0], 8'h81);
    hacc(1, 2'h3, 0, 0, 0);
    check("next low byte", q[7:0], 8'h11);
    $display("test byte done");
  endtask
  task t_ctrl;
    hacc(0, 2'h0, 0, 0, 16'h005a);
    check("host ctrl", ctrl[7:0], 8'h5a);
    @(negedge clock); cwd = 16'h1234; cwr = 1'b1;
    @(negedge clock); cwr = 1'b0;
    check("dsp ctrl", ctrl, 16'h1234);
    hacc(1, 2'h0, 1, 0, 0);
    check("ctrl high read", q[7:0], 8'h12);
    $display("test ctrl done");
  endtask
  task t_half;
    ds_pick = 1'b1;
    hacc(0, 0, 0, 18'h00060, 16'h1234);
    check("scratch write", u_hpm_mem_model.mem[18'h60], 16'h1234);
    hacc(0, 0, 0, 18'h3ffff, 16'hbeef);
    check("top write", u_hpm_mem_model.mem[18'h3ffff], 16'hbeef);
    check("ctrl untouched", ctrl, 16'h1234);
    hacc(1, 0, 0, 18'h3ffff, 0);
    check("half read", q, 16'hbeef);
    check("oe idle", oe, 1'b0);
    check("oe on read", qoe, 1'b1);
    $display("test halfword done");
  endtask
  task t_reserved;
    logic [17:0] ra [4];
    ra = '{18'h0005f, 18'h08000, 18'h20000, 18'h30000};
    foreach (ra[j]) begin
      hacc(0, 0, 0, ra[j], 16'hffff);
      hacc(1, 0, 0, ra[j], 0);
      check("reserved read", q, 16'h0000);
      check("reserved flag", rsv, 1'b1);
      check("write dropped", u_hpm_mem_model.mem[ra[j]], 16'h0000);
    end
    $display("test reserved done");
  endtask
  task t_stall;
    @(negedge clock);
    stall_seen = 0;
    wcyc = 4'h4;
    dmem = 1'b1;
    hacc(1, 0, 0, 18'h00060, 0);
    @(negedge clock);
    dmem = 1'b0;
    wcyc = 4'h0;
    check("slow read", q, 16'h1234);
    check("ram flag", rsv, 1'b0);
    check("dsp stalled", stall_seen != 0, 1'b1);
    $display("test stall done");
  endtask
  task t_keep;
    @(negedge clock);
    addr = 18'h2a5a5;
    hd_drv = 16'h3c3c;
    for (i = 0; i < 4; i++) begin
      @(negedge clock); strap = i[1]; keep_en = i[0];
      repeat (2) @(negedge clock);
      check("data keeper", dko, i[1] | i[0]);
      check("addr keeper", ako, i[1] & i[0]);
      check("data level", dkl, 16'h3c3c);
      check("addr level", akl, 18'h2a5a5);
    end
    $display("test keeper done");
  endtask
  task t_reset;
    @(negedge clock);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    check("reset ctrl", ctrl, 16'h0000);
    check("reset ready", rdy, 1'b0);
    check("reset keeper", dko, 1'b0);
    // no access while reset is held
    rst_n = 1'b1;
    hacc(1, 0, 0, 18'h3ffff, 0);
    check("read after reset", q, 16'hbeef);
    $display("test reset done");
  endtask
  initial begin
    rst_n = 0; strap = 0; keep_en = 0; cs_n = 1; ds1_n = 1; rw = 1; half = 0; dmem = 0;
    ds2_n = 1;
    ds_pick = 0;
    cwr = 0; sel = 0; wcyc = 0; addr = 0; hd_drv = 16'h00ff; cwd = 0;
    err_count = 0; n_tests = 0;
    repeat (20) @(negedge clock);
    rst_n = 1;
    t_byte; t_ctrl;
    @(negedge clock); strap = 1'b1;
    t_half; t_reserved; t_stall; t_keep; t_reset;
    report_and_stop;
  end
endmodule
`default_nettype wire

// ### verilog/hpm_host_port.v
// host port: external host access to on-chip ram over the internal dma bus
`timescale 1ns/1ps
`default_nettype none
`include "hpm_map.vh"

// Summary of operation
// RL1 - strap high gives 16-bit host port, low gives 8-bit port
// RL2 - byte mode moves each word as two bytes chosen by byte-half select
// RL3 - byte mode has address, data and control registers; control shared with dsp
// RL4 - sequential transfers auto-increment the address; random transfers do not
// RL5 - transfers continue during emulation stop and reach all ram via dma
// RL6 - halfword mode only uses separate address and data buses
// RL7 - halfword mode takes an 18-bit address covering all internal memory
// RL8 - wait/ready holds the host off while the dma transfer is pending
// RL9 - accesses run on the dsp clock; contention stalls dsp one cycle
// RL10 - system keeps input clock running for accesses during idle
// RL11 - host makes no access while device reset is asserted
// RL12 - halfword mode: data over 16-bit bus, address over 18-bit bus
// RL13 - host starts access with select and strobes, direction by read/write
// RL14 - control register not reachable in halfword mode
// RL15 - every halfword-mode access launches a dma read or write; reserved addresses launch none here
// RL16 - addresses decode to scratch, dual and single access ram, rest reserved
// RL17 - host holds strobes until ready, then ends access and samples data
// RL18 - with strap and keeper enable high, keepers hold data and address lines
module hpm_host_port (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        halfword_width_strap,
  input  wire        host_bus_keeper_enable,
  input  wire        host_chip_select_n,
  input  wire        data_strobe_one_n,
  input  wire        data_strobe_two_n,
  input  wire        host_read_write_select,
  input  wire        byte_half_select,
  input  wire [1:0]  access_control_select,
  input  wire [17:0] host_address_bus,
  input  wire [15:0] host_data_bus_in,
  output reg  [15:0] host_data_bus_out,
  output reg         host_data_bus_oe,
  output reg         host_wait_ready,
  output reg         dma_req,
  output reg         dma_we,
  output reg  [17:0] dma_addr,
  output reg  [15:0] dma_wdata,
  input  wire [15:0] dma_rdata,
  input  wire        dma_ack,
  input  wire        dsp_mem_req,
  output reg         dsp_stall,
  input  wire        dsp_ctrl_wr,
  input  wire [15:0] dsp_ctrl_wdata,
  output reg  [15:0] host_control_reg,
  output reg         addr_reserved,
  output reg         data_keeper_on,
  output reg         addr_keeper_on,
  output reg  [15:0] data_keeper_level,
  output reg  [17:0] addr_keeper_level
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_DMA  = 2'h1;
  localparam [1:0] ST_DONE = 2'h2;

  reg  [1:0]  state_q;
  reg         strobe_q;
  reg  [17:0] host_address_reg_q;
  reg  [15:0] host_data_reg_q;
  reg         inc_pend_q;
  wire        strobe;
  wire        start;
  wire        rd;
  wire        byte_wide_port_mode;

  // address decode: high when the location maps onto on-chip ram
  function ram_hit;
    input [17:0] a;
    begin
      ram_hit = (a >= `HPM_SCRATCH_LO && a <= `HPM_SCRATCH_HI) ||
                (a >= `HPM_DUAL0_LO && a <= `HPM_DUAL0_HI) ||
                (a >= `HPM_DUAL1_LO && a <= `HPM_DUAL1_HI) ||
                (a >= `HPM_SINGLE0_LO && a <= `HPM_SINGLE0_HI) ||
                (a >= `HPM_SINGLE1_LO && a <= `HPM_SINGLE1_HI);
    end
  endfunction

  // ----------------------------------------------------------------
  // access detection
  // ----------------------------------------------------------------
  // RL13 select and strobe
  assign strobe = !host_chip_select_n && !(data_strobe_one_n && data_strobe_two_n);
  assign start  = strobe && !strobe_q;
  assign rd     = host_read_write_select;        // high = read
  // RL1 width from strap
  assign byte_wide_port_mode = !halfword_width_strap;

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  // one access at a time, all on the dsp clock
  always @(posedge clock) begin
    if (!rst_n) begin
      state_q            <= ST_IDLE;
      strobe_q           <= 1'b0;
      host_address_reg_q <= `HPM_ADDR_RST;
      host_data_reg_q    <= `HPM_WORD_RST;
      inc_pend_q         <= 1'b0;
      host_data_bus_out  <= `HPM_WORD_RST;
      host_data_bus_oe   <= 1'b0;
      host_wait_ready    <= 1'b0;
      dma_req            <= 1'b0;
      dma_we             <= 1'b0;
      dma_addr           <= `HPM_ADDR_RST;
      dma_wdata          <= `HPM_WORD_RST;
      host_control_reg   <= `HPM_CTRL_RST;
      addr_reserved      <= 1'b0;
    end else begin
      strobe_q <= strobe;
      // dsp side of the shared control register
      if (dsp_ctrl_wr) begin
        host_control_reg <= dsp_ctrl_wdata;
      end
      case (state_q)
        ST_IDLE: begin
          // RL14 no control access
          if (start && !byte_wide_port_mode) begin
            // RL6 RL12 separate buses
            // RL7 full 18-bit address
            // RL15 every ram access uses dma, reserved ones none
            host_address_reg_q <= host_address_bus;
            dma_addr           <= host_address_bus;
            dma_we             <= !rd;
            dma_wdata          <= host_data_bus_in;
            inc_pend_q         <= 1'b0;
            // RL16 reserved decode
            if (ram_hit(host_address_bus)) begin
              dma_req       <= 1'b1;
              addr_reserved <= 1'b0;
              state_q       <= ST_DMA;
            end else begin
              addr_reserved     <= 1'b1;
              host_data_bus_out <= `HPM_WORD_RST;
              state_q           <= ST_DONE;
            end
          end else if (start) begin
            addr_reserved <= 1'b0;
            state_q       <= ST_DONE;
            case (access_control_select)
              `HPM_SEL_CTRL: begin
                // RL3 host view of control
                if (rd) begin
                  host_data_bus_out <= byte_half_select ?
                    {8'h00, host_control_reg[15:8]} : {8'h00, host_control_reg[7:0]};
                end else if (!dsp_ctrl_wr && byte_half_select) begin
                  host_control_reg[15:8] <= host_data_bus_in[7:0];
                end else if (!dsp_ctrl_wr) begin
                  host_control_reg[7:0] <= host_data_bus_in[7:0];
                end
              end
              `HPM_SEL_ADDR: begin
                // RL3 host-only address register
                if (rd) begin
                  host_data_bus_out <= byte_half_select ?
                    {8'h00, host_address_reg_q[15:8]} : {8'h00, host_address_reg_q[7:0]};
                end else if (byte_half_select) begin
                  host_address_reg_q[15:8] <= host_data_bus_in[7:0];
                end else begin
                  host_address_reg_q[7:0] <= host_data_bus_in[7:0];
                end
              end
              default: begin
                // RL2 low byte first, high byte second
                // RL4 increment only for sequential select
                inc_pend_q <= (access_control_select == `HPM_SEL_DATA_INC);
                if (rd && !byte_half_select) begin
                  dma_addr <= host_address_reg_q;
                  dma_we   <= 1'b0;
                  if (ram_hit(host_address_reg_q)) begin
                    dma_req <= 1'b1;
                    state_q <= ST_DMA;
                  end else begin
                    addr_reserved     <= 1'b1;
                    host_data_reg_q   <= `HPM_WORD_RST;
                    host_data_bus_out <= `HPM_WORD_RST;
                  end
                end else if (rd) begin
                  host_data_bus_out <= {8'h00, host_data_reg_q[15:8]};
                  if (access_control_select == `HPM_SEL_DATA_INC) begin
                    host_address_reg_q <= host_address_reg_q + 18'h00001;
                  end
                end else if (!byte_half_select) begin
                  host_data_reg_q[7:0] <= host_data_bus_in[7:0];
                end else begin
                  dma_addr  <= host_address_reg_q;
                  dma_we    <= 1'b1;
                  dma_wdata <= {host_data_bus_in[7:0], host_data_reg_q[7:0]};
                  host_data_reg_q[15:8] <= host_data_bus_in[7:0];
                  if (ram_hit(host_address_reg_q)) begin
                    dma_req <= 1'b1;
                    state_q <= ST_DMA;
                  end else begin
                    addr_reserved <= 1'b1;
                  end
                end
              end
            endcase
          end
        end
        ST_DMA: begin
          // RL8 ready held low while dma pending
          // RL5 not gated by emulation stop
          if (dma_ack) begin
            dma_req <= 1'b0;
            state_q <= ST_DONE;
            if (!dma_we) begin
              host_data_reg_q   <= dma_rdata;
              host_data_bus_out <= byte_wide_port_mode ? {8'h00, dma_rdata[7:0]} : dma_rdata;
            end
            // RL4 bump after the word is written
            if (byte_wide_port_mode && dma_we && inc_pend_q) begin
              host_address_reg_q <= host_address_reg_q + 18'h00001;
            end
          end
        end
        ST_DONE: begin
          // RL17 ready until the host lets go
          host_wait_ready  <= strobe;
          host_data_bus_oe <= strobe && rd;
          if (!strobe) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // dsp contention and bus keepers
  // ----------------------------------------------------------------
  // RL9 one-cycle dsp stall
  always @(posedge clock) begin
    if (!rst_n) begin
      dsp_stall <= 1'b0;
    end else begin
      dsp_stall <= dma_req && !dma_ack && dsp_mem_req && !dsp_stall;
    end
  end

  // RL18 keeper enables and levels
  always @(posedge clock) begin
    if (!rst_n) begin
      data_keeper_on    <= 1'b0;
      addr_keeper_on    <= 1'b0;
      data_keeper_level <= `HPM_WORD_RST;
      addr_keeper_level <= `HPM_ADDR_RST;
    end else begin
      data_keeper_on    <= halfword_width_strap || host_bus_keeper_enable;
      addr_keeper_on    <= halfword_width_strap && host_bus_keeper_enable;
      data_keeper_level <= host_data_bus_oe ? host_data_bus_out : host_data_bus_in;
      addr_keeper_level <= host_address_bus;
    end
  end

endmodule
`default_nettype wire

// ### verilog/hpm_map.vh
// constants for the host port memory access block
`ifndef HPM_MAP_VH
`define HPM_MAP_VH

// ----------------------------------------------------------------
// byte-wide access control select codes
// ----------------------------------------------------------------
`define HPM_SEL_CTRL      2'h0
`define HPM_SEL_DATA_INC  2'h1
`define HPM_SEL_ADDR      2'h2
`define HPM_SEL_DATA      2'h3

// ----------------------------------------------------------------
// host address decode limits
// ----------------------------------------------------------------
`define HPM_SCRATCH_LO    18'h00060
`define HPM_SCRATCH_HI    18'h0007f
`define HPM_DUAL0_LO      18'h00080
`define HPM_DUAL0_HI      18'h07fff
`define HPM_DUAL1_LO      18'h18000
`define HPM_DUAL1_HI      18'h1ffff
`define HPM_SINGLE0_LO    18'h28000
`define HPM_SINGLE0_HI    18'h2ffff
`define HPM_SINGLE1_LO    18'h38000
`define HPM_SINGLE1_HI    18'h3ffff

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define HPM_ADDR_RST      18'h00000
`define HPM_WORD_RST      16'h0000
`define HPM_CTRL_RST      16'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HPM_DSP_STALL_CYC 1

`endif
